// ==== dv/cct_ctrl_sva.sv ====
// Checker for bus timing, divider decode, loop enables and crystal alarm
`timescale 1ns/100ps
module cct_ctrl_chk (
  // Clock, reset, bus
  input wire        clk,
  input wire        rst,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  // Monitored edges, crystal alarm and loop settings
  input wire        xtal_edge,
  input wire        fb_up_edge,
  input wire        xtal_bad,
  input wire [10:0] out_div_code_q,
  input wire [10:0] out_div_ratio,
  input wire        lower_loop_en,
  input wire        ref_path_en,
  input wire        frac_en
);
  reg [1:0] cnt_q;
  reg [1:0] cnt_d;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Ratio expected from a divider code
  function [10:0] dr(input [10:0] c);
    dr = (c < 11'h003) ? 11'h002 : (c < 11'h006) ? c : {c[10:1], 1'b0};
  endfunction
  // Feedback edges since the last crystal edge
  always @* begin
    cnt_d = cnt_q;
    if (xtal_edge)
      cnt_d = 2'h0;
    else if (fb_up_edge && cnt_q != 2'h3)
      cnt_d = cnt_q + 2'h1;
  end
  always @(posedge clk) begin
    if (rst)
      cnt_q <= 2'h0;
    else
      cnt_q <= cnt_d;
  end
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("bad response");
  property p_rd_wait;
    hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_one_wait; !hreadyout |=> hreadyout; endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait too long");
  property p_ratio; out_div_ratio == dr($past(out_div_code_q)); endproperty
  a_ratio: assert property (p_ratio) else $error("ratio decode");
  property p_range; out_div_ratio >= 11'h002 && out_div_ratio <= 11'h7FE; endproperty
  a_range: assert property (p_range) else $error("ratio range");
  property p_lower; lower_loop_en |-> ref_path_en; endproperty
  a_lower: assert property (p_lower) else $error("lower loop");
  property p_frac; frac_en |-> !ref_path_en && !lower_loop_en; endproperty
  a_frac: assert property (p_frac) else $error("synth loops");
  property p_xclr; xtal_edge |=> !xtal_bad; endproperty
  a_xclr: assert property (p_xclr) else $error("alarm not cleared");
  property p_xset; xtal_bad == (cnt_q == 2'h3); endproperty
  a_xset: assert property (p_xset) else $error("alarm count");
  // Main scenarios
  c_rd: cover property (hsel && htrans[1] && !hwrite);
  c_bad: cover property ($rose(xtal_bad));
  c_odd: cover property (out_div_ratio == 11'h005);
endmodule // cct_ctrl_chk
bind cct_ctrl cct_ctrl_chk u_chk (.*);

// ==== dv/cct_host.sv ====
// Bus master model standing in for the configuration host
`timescale 1ns/100ps
module cct_host (
  // Clock and answer
  input  wire        clk,
  input  wire        hready,
  input  wire [31:0] hrdata,
  // Request
  output reg         hsel = 1'b1,
  output reg  [7:0]  haddr = 8'h00,
  output reg  [1:0]  htrans = 2'h0,
  output reg         hwrite = 1'b0,
  output reg  [2:0]  hsize = 3'h2,
  output reg  [31:0] hwdata = 32'h0
);
  // Bounded wait for hready high at a rising edge
  task hold(output bit ok);
    ok = 1'b0;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(posedge clk);
      ok = (hready === 1'b1);
    end
  endtask
  // One word transfer; values written are volatile
  task xfer(input bit w, input [7:0] a, input [31:0] wd, output [31:0] rd,
            output bit ok);
    bit k;
    @(posedge clk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hold(k);
    htrans <= 2'h0;
    hwdata <= wd;
    hold(ok);
    ok = ok & k;
    rd = hrdata;
  endtask
endmodule // cct_host

// ==== dv/clock_translator_config_control_tb.sv ====
// Testbench for the translator configuration control
`timescale 1ns/100ps
`include "cct_defs.vh"
module clock_translator_config_control_tb;
  localparam [75:0] c0 = `CCT_CFG0;
  localparam [75:0] c1 = `CCT_CFG1;
  reg clk = 1'b0, rst = 1'b1, profile_pin = 1'b0, clk_sel_pin = 1'b0, pll_locked = 1'b0;
  reg ref_a_edge = 1'b0, ref_b_edge = 1'b0, xtal_edge = 1'b0, fb_up_edge = 1'b0;
  reg fb_lo_edge = 1'b0;
  wire hsel, hwrite, hreadyout, hresp, ref_a_bad, ref_b_bad, xtal_bad, holdover;
  wire ref_active, upper_loop_en, lower_loop_en, ref_path_en, frac_en, xtal_double;
  wire [1:0]  htrans;
  wire [2:0]  hsize;
  wire [7:0]  haddr;
  wire [31:0] hwdata, hrdata, fb_div_q;
  wire [10:0] out_div_code_q, out_div_ratio;
  wire [15:0] pre_div_q;
  wire [16:0] m1_div_q;
  wire        hready = hreadyout;
  int bad_count = 0, samples_checked = 0;
  logic [10:0] codes [10] = '{0, 1, 2, 3, 4, 5, 6, 7, 11'h7FE, 11'h7FF}; // Host codes
  cct_ctrl DUT (.*);
  cct_host HOST (.*);
  // Clock
  always #25 clk = ~clk;
  function [10:0] dr(input [10:0] c);
    dr = (c < 3) ? 11'h002 : (c < 6) ? c : {c[10:1], 1'b0};
  endfunction
  task conclude;
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task xf(input bit w, input [7:0] a, input [31:0] d, output [31:0] r);
    bit ok;
    HOST.xfer(w, a, d, r, ok);
    if (!ok) begin
      bad_count++;
      conclude();
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    logic [31:0] r;
    xf(1'b1, a, d, r);
  endtask
  task rc(input [7:0] a, input [31:0] e);
    logic [31:0] r;
    xf(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task settle;
    repeat (3) @(negedge clk);
  endtask
  task ldchk(input [75:0] c);
    repeat (6) @(negedge clk);
    chk(out_div_code_q, c[10:0]);
    chk(pre_div_q, c[26:11]);
    chk(fb_div_q, c[58:27]);
    chk(m1_div_q, c[75:59]);
  endtask
  task pulse(input [4:0] v);
    @(posedge clk) {fb_lo_edge, fb_up_edge, xtal_edge, ref_b_edge, ref_a_edge} <= v;
    @(posedge clk) {fb_lo_edge, fb_up_edge, xtal_edge, ref_b_edge, ref_a_edge} <= 5'h00;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    ldchk(c0);
    rc(8'h14, 32'h0000_0180);
    @(posedge clk) profile_pin <= 1'b1;
    ldchk(c1);
    wr(8'h00, 32'h0000_0001);
    ldchk(c0);
    wr(8'h0C, 32'h0100_0001);
    rc(8'h0C, 32'h0100_0001);
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, {27'h0, m == 2, m[1:0], 2'b01});
      settle();
      chk(lower_loop_en, m == 0);
      chk(ref_path_en, m < 2);
      chk(upper_loop_en, 1);
      chk(frac_en, m == 2);
      chk(xtal_double, m == 2);
      chk(out_div_code_q, c0[10:0]);
    end
    wr(8'h00, 32'h0000_001B);
    ldchk(c1);
    chk(ref_path_en, 0);
    foreach (codes[i]) begin
      wr(8'h04, codes[i]);
      rc(8'h04, codes[i]);
      rc(8'h18, dr(codes[i]));
      chk(out_div_ratio, dr(codes[i]));
    end
    wr(8'h40, 32'hFFFF_FFFF);
    rc(8'h40, 32'h0);
    repeat (3) pulse(5'b01001);
    settle();
    chk({xtal_bad, ref_b_bad, ref_a_bad}, 3'h6);
    pulse(5'b00100);
    settle();
    chk(xtal_bad, 0);
    @(posedge clk) clk_sel_pin <= 1'b1;
    settle();
    chk({holdover, ref_active}, 2'h3);
    wr(8'h00, 32'h0000_005B);
    @(posedge clk) pll_locked <= 1'b1;
    settle();
    chk(ref_active, 0);
    repeat (3) pulse(5'b01010);
    settle();
    chk({holdover, ref_active}, 2'h1);
    pulse(5'b00001);
    settle();
    chk(ref_active, 0);
    wr(8'h00, 32'h0000_00BB);
    settle();
    chk({holdover, ref_active}, 2'h1);
    // Reset after reconfiguring; stored profile returns
    @(posedge clk) rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    ldchk(c1);
    conclude();
  end
endmodule // clock_translator_config_control_tb

// ==== rtl/cct_cfg_store.v ====
// Two-entry store holding the power-up default configurations
`timescale 1ns/100ps
module cct_cfg_store #(
  parameter          W    = 76,
  parameter [W-1:0]  CFG0 = {W{1'b0}},
  parameter [W-1:0]  CFG1 = {W{1'b0}}
) (
  // Clock
  input  wire          clk,
  // Read port
  input  wire          sel,
  output reg  [W-1:0]  rdata
);

  // Registered read of the chosen entry
  always @(posedge clk) begin
    rdata <= sel ? CFG1 : CFG0;
  end

endmodule // cct_cfg_store

// ==== rtl/cct_ctrl.v ====
// Configuration, mode, divider and reference control of the translator
//
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "cct_defs.vh"
module cct_ctrl #(
  // Mode code for each operating mode
  parameter [1:0]  MODE_LBW = `CCT_MODE_LBW,
  parameter [1:0]  MODE_HBW = `CCT_MODE_HBW,
  parameter [1:0]  MODE_SYN = `CCT_MODE_SYN
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst,
  // AHB-Lite slave
  input  wire         hsel,
  input  wire [7:0]   haddr,
  input  wire [1:0]   htrans,
  input  wire         hwrite,
  input  wire [2:0]   hsize,
  input  wire [31:0]  hwdata,
  input  wire         hready,
  output wire         hreadyout,
  output wire         hresp,
  output reg  [31:0]  hrdata,
  // Profile pin, reference select pin, lock
  input  wire         profile_pin,
  input  wire         clk_sel_pin,
  input  wire         pll_locked,
  // Monitored edge pulses
  input  wire         ref_a_edge,
  input  wire         ref_b_edge,
  input  wire         xtal_edge,
  input  wire         fb_up_edge,
  input  wire         fb_lo_edge,
  // Alarm pins and active reference
  output wire         ref_a_bad,
  output wire         ref_b_bad,
  output wire         xtal_bad,
  output reg          holdover,
  output reg          ref_active,
  // Loop settings
  output reg  [10:0]  out_div_code_q,
  output reg  [10:0]  out_div_ratio,
  output reg  [15:0]  pre_div_q,
  output reg  [31:0]  fb_div_q,
  output reg  [16:0]  m1_div_q,
  output reg          upper_loop_en,
  output reg          lower_loop_en,
  output reg          ref_path_en,
  output reg          frac_en,
  output reg          xtal_double
);

  // Control register and loader state
  reg  [7:0]   ctrl_q;
  reg  [1:0]   st_q;
  reg          cur_prof_q;
  // Bus data-phase tracking
  reg          ap_wr_q;
  reg          ap_rd_q;
  reg          rd_rdy_q;
  reg  [7:0]   ap_addr_q;
  // Lock seen since an automatic policy was chosen
  reg          lock_seen_q;
  // Combinational read mux and decoded ratio
  reg  [31:0]  rd_mux;
  reg  [10:0]  ratio_d;
  // Store read data and alarm levels
  wire [`CCT_CFG_W-1:0] cfg_rd;
  wire [2:0]   bad;
  // Decoded bus and control fields
  wire         accept;
  wire         prof_sel;
  wire [1:0]   mode;
  wire [1:0]   pol;
  wire         pref;

  // Control fields: mode, policy, preferred reference
  assign mode     = ctrl_q[`CCT_CTRL_MODE_L+1:`CCT_CTRL_MODE_L];
  assign pol      = ctrl_q[`CCT_CTRL_POL_L+1:`CCT_CTRL_POL_L];
  assign pref     = ctrl_q[`CCT_CTRL_CSEL];
  // Active profile: ctrl_q profile bit when source bit set, else pin (low = zero, high = one)
  assign prof_sel = ctrl_q[`CCT_CTRL_SRC] ? ctrl_q[`CCT_CTRL_PROF] : profile_pin;

  // Stored defaults, read through a register
  cct_cfg_store #(
    .W    (`CCT_CFG_W),
    .CFG0 (`CCT_CFG0),
    .CFG1 (`CCT_CFG1)
  ) u_store (
    .clk   (clk),
    .sel   (cur_prof_q),
    .rdata (cfg_rd)
  );

  // Bus handshake: reads take one wait state, writes none
  assign accept    = hsel & hready & htrans[1];
  assign hreadyout = ~ap_rd_q | rd_rdy_q;
  assign hresp     = 1'b0;

  // Address phase capture
  always @(posedge clk) begin
    if (rst) begin
      ap_wr_q   <= 1'b0;
      ap_rd_q   <= 1'b0;
      rd_rdy_q  <= 1'b0;
      ap_addr_q <= 8'h00;
    end else begin
      if (hreadyout) begin
        ap_wr_q   <= accept & hwrite;
        ap_rd_q   <= accept & ~hwrite;
        rd_rdy_q  <= 1'b0;
        ap_addr_q <= haddr;
      end else begin
        rd_rdy_q  <= 1'b1;
      end
    end
  end

  // Read data mux, unmapped reads zero
  always @* begin
    rd_mux = 32'h00000000;
    case (ap_addr_q)
      `CCT_OFF_CTRL:   rd_mux = {24'h000000, ctrl_q};
      `CCT_OFF_OUTDIV: rd_mux = {21'h000000, out_div_code_q};
      `CCT_OFF_PREDIV: rd_mux = {16'h0000, pre_div_q};
      `CCT_OFF_FBDIV:  rd_mux = fb_div_q;
      `CCT_OFF_M1DIV:  rd_mux = {15'h0000, m1_div_q};
      `CCT_OFF_STATUS: rd_mux = {21'h000000, holdover, ref_active, lower_loop_en,
                                 upper_loop_en, frac_en, bad, st_q != `CCT_ST_IDLE,
                                 cur_prof_q, 1'b0};
      `CCT_OFF_RATIO:  rd_mux = {21'h000000, out_div_ratio};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  // Read data register, loaded in the wait cycle
  always @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (ap_rd_q & ~rd_rdy_q) begin
      hrdata <= rd_mux;
    end
  end

  // Control register; mode not part of the stored profiles
  always @(posedge clk) begin
    if (rst) begin
      ctrl_q <= `CCT_CTRL_RST;
    end else if (ap_wr_q && ap_addr_q == `CCT_OFF_CTRL) begin
      ctrl_q <= hwdata[7:0];
    end
  end

  // Loader: fetch on reset release and on profile change
  always @(posedge clk) begin
    if (rst) begin
      st_q       <= `CCT_ST_FETCH;
      cur_prof_q <= 1'b0;
    end else begin
      case (st_q)
        `CCT_ST_IDLE: begin
          if (prof_sel != cur_prof_q) begin
            st_q <= `CCT_ST_FETCH;
          end
        end
        `CCT_ST_FETCH: begin
          cur_prof_q <= prof_sel;
          st_q       <= `CCT_ST_WAIT;
        end
        `CCT_ST_WAIT: begin
          st_q <= `CCT_ST_COPY;
        end
        `CCT_ST_COPY: begin
          st_q <= `CCT_ST_IDLE;
        end
        default: begin
          st_q <= `CCT_ST_IDLE;
        end
      endcase
    end
  end

  // Live profile registers: copied from store, else host writable
  always @(posedge clk) begin
    if (rst) begin
      out_div_code_q <= 11'h000;
      pre_div_q      <= 16'h0000;
      fb_div_q       <= 32'h00000000;
      m1_div_q       <= 17'h00000;
    end else if (st_q == `CCT_ST_COPY) begin
      // Stored profile replaces any earlier host values
      out_div_code_q <= cfg_rd[10:0];
      pre_div_q      <= cfg_rd[26:11];
      fb_div_q       <= cfg_rd[58:27];
      m1_div_q       <= cfg_rd[75:59];
    end else if (ap_wr_q && st_q == `CCT_ST_IDLE) begin
      // Host writes dropped while the loader is busy
      case (ap_addr_q)
        `CCT_OFF_OUTDIV: out_div_code_q <= hwdata[10:0];
        `CCT_OFF_PREDIV: pre_div_q      <= hwdata[15:0];
        `CCT_OFF_FBDIV:  fb_div_q       <= hwdata;
        `CCT_OFF_M1DIV:  m1_div_q       <= hwdata[16:0];
        default:         m1_div_q       <= m1_div_q;
      endcase
    end
  end

  // Output divider decode, ratio 2..2046
  always @* begin
    if (out_div_code_q <= 11'h002) begin
      ratio_d = 11'h002;
    end else if (out_div_code_q <= 11'h005) begin
      ratio_d = out_div_code_q;
    end else begin
      ratio_d = {out_div_code_q[10:1], 1'b0};
    end
  end

  // Loop organisation per mode
  always @(posedge clk) begin
    if (rst) begin
      out_div_ratio <= 11'h002;
      upper_loop_en <= 1'b0;
      lower_loop_en <= 1'b0;
      ref_path_en   <= 1'b0;
      frac_en       <= 1'b0;
      xtal_double   <= 1'b0;
    end else begin
      // Mode code 3 leaves reference path and lower loop off
      out_div_ratio <= ratio_d;
      upper_loop_en <= 1'b1;
      lower_loop_en <= (mode == MODE_LBW);
      ref_path_en   <= (mode == MODE_LBW) | (mode == MODE_HBW);
      frac_en       <= (mode == MODE_SYN) & (fb_div_q[23:0] != 24'h000000);
      xtal_double   <= ctrl_q[`CCT_CTRL_DBL];
    end
  end

  // Missing-edge monitors: three feedback edges without input edge
  // Source edge wins over a feedback edge in the same cycle
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_mon
      reg  [1:0] cnt_q;
      reg        bad_q;
      wire       src_e;
      wire       fb_e;
      assign src_e  = (i == 0) ? ref_a_edge : (i == 1) ? ref_b_edge : xtal_edge;
      assign fb_e   = (i < 2 && mode == MODE_LBW) ? fb_lo_edge : fb_up_edge;
      assign bad[i] = bad_q;
      always @(posedge clk) begin
        if (rst) begin
          cnt_q <= 2'h0;
          bad_q <= 1'b0;
        end else if (src_e) begin
          cnt_q <= 2'h0;
          bad_q <= 1'b0;
        end else if (fb_e && cnt_q != `CCT_BAD_EDGES) begin
          cnt_q <= cnt_q + 2'h1;
          bad_q <= (cnt_q == `CCT_BAD_EDGES - 2'h1);
        end
      end
    end
  endgenerate

  // Alarm pins mirror the monitor flags
  assign ref_a_bad = bad[0];
  assign ref_b_bad = bad[1];
  assign xtal_bad  = bad[2];

  // Reference selection and holdover
  always @(posedge clk) begin
    if (rst) begin
      ref_active  <= 1'b0;
      holdover    <= 1'b0;
      lock_seen_q <= 1'b0;
    end else begin
      lock_seen_q <= (pol[1] & (lock_seen_q | pll_locked));
      case (pol)
        `CCT_POL_MPIN: begin
          ref_active <= clk_sel_pin;
          holdover   <= bad[ref_active];
        end
        `CCT_POL_MREG: begin
          ref_active <= pref;
          holdover   <= bad[ref_active];
        end
        default: begin
          holdover <= bad[0] & bad[1];
          // Preferred input held until lock first seen
          if (!lock_seen_q) begin
            ref_active <= pref;
          end else if (bad[ref_active] && !bad[~ref_active]) begin
            ref_active <= ~ref_active;
          end else if (pol == `CCT_POL_REV && ref_active != pref && !bad[pref]) begin
            ref_active <= pref;
          end
        end
      endcase
    end
  end

endmodule // cct_ctrl

// ==== rtl/cct_defs.vh ====
// Constants for the clock translator configuration control block
`ifndef CCT_DEFS_VH
`define CCT_DEFS_VH

// Register byte offsets
`define CCT_OFF_CTRL    8'h00
`define CCT_OFF_OUTDIV  8'h04
`define CCT_OFF_PREDIV  8'h08
`define CCT_OFF_FBDIV   8'h0C
`define CCT_OFF_M1DIV   8'h10
`define CCT_OFF_STATUS  8'h14
`define CCT_OFF_RATIO   8'h18

// Control field positions
`define CCT_CTRL_SRC    0
`define CCT_CTRL_PROF   1
`define CCT_CTRL_MODE_L 2
`define CCT_CTRL_DBL    4
`define CCT_CTRL_POL_L  5
`define CCT_CTRL_CSEL   7

// Control reset value: pin source, mode code 0, manual via pin
`define CCT_CTRL_RST    8'h00

// Mode codes
`define CCT_MODE_LBW    2'h0
`define CCT_MODE_HBW    2'h1
`define CCT_MODE_SYN    2'h2

// Switching policies
`define CCT_POL_MPIN    2'h0
`define CCT_POL_MREG    2'h1
`define CCT_POL_REV     2'h2
`define CCT_POL_NREV    2'h3

// Loader states
`define CCT_ST_IDLE     2'h0
`define CCT_ST_FETCH    2'h1
`define CCT_ST_WAIT     2'h2
`define CCT_ST_COPY     2'h3

// Missing-edge alarm threshold in feedback edges
`define CCT_BAD_EDGES   2'h3

// Stored configuration word: {m1[16:0], fb[31:0], pre[15:0], n[10:0]}
`define CCT_CFG_W       76
`define CCT_CFG0        76'h0010_00001900_0001_004
`define CCT_CFG1        76'h0020_00002000_0002_010

`endif
